// ---- src/exc_pkg.sv ----
// Shared constants and carrier types for the exception sequencer
`default_nettype none
package exc_pkg;
    localparam int VEC_W = 6;
    localparam int ADDR_W = 16;
    localparam int WORD_W = 32;
    localparam int EXT_LINES = 6;
    localparam int INT_SRC = 30;
    localparam logic [VEC_W-1:0] VEC_RESET = 6'h00;
    localparam logic [VEC_W-1:0] VEC_NMI = 6'h07;
    localparam logic [VEC_W-1:0] VEC_TRAP_BASE = 6'h08;
    localparam logic [VEC_W-1:0] VEC_EXT_BASE = 6'h0C;
    localparam logic [VEC_W-1:0] VEC_INT_FIRST = 6'h14;
    localparam logic [VEC_W-1:0] VEC_INT_LAST = 6'h3C;
    localparam logic [VEC_W-1:0] VEC_RSV_HI0 = 6'h12;
    localparam logic [VEC_W-1:0] VEC_RSV_HI1 = 6'h13;
    localparam int VEC_SHIFT = 2;
    localparam int MASK_BIT = 7;
    localparam logic [7:0] FLAG_RESET = 8'h80;
    localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;

    // Request from the core: trap instruction seen, its operand
    typedef struct packed {
        logic trap_valid;
        logic [1:0] trap_operand;
        logic boundary;
    } core_req_t;

    // One bus access issued by the sequencer
    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } bus_req_t;
endpackage
`default_nettype wire

// ---- src/exc_vector_map.sv ----
// Vector number to table entry address mapping and source encoding
`timescale 1ns/1ps
`default_nettype none
module exc_vector_map (
    input wire logic [1:0] kind,
    input wire logic [2:0] ext_index,
    input wire logic [1:0] trap_operand,
    input wire logic [5:0] int_vector,
    output logic [5:0] vector,
    output logic [15:0] entry_addr,
    output logic legal
);
    function automatic logic reserved_vec(input logic [5:0] v);
        reserved_vec = (v >= 6'h01 && v <= 6'h06) || v == exc_pkg::VEC_RSV_HI0 || v == exc_pkg::VEC_RSV_HI1;
    endfunction

    always_comb begin
        unique case (kind)
            2'h0: vector = exc_pkg::VEC_RESET;
            2'h1: vector = exc_pkg::VEC_TRAP_BASE + {4'h0, trap_operand};
            2'h2: vector = (ext_index == 3'h7) ? exc_pkg::VEC_NMI
                          : exc_pkg::VEC_EXT_BASE + {3'h0, ext_index};
            default: vector = int_vector;
        endcase
        legal = !reserved_vec(vector) && vector <= exc_pkg::VEC_INT_LAST
                && (kind != 2'h3 || vector >= exc_pkg::VEC_INT_FIRST);
        entry_addr = {8'h00, vector, 2'h0};
    end
endmodule // exc_vector_map
`default_nettype wire

// ---- src/exc_sequencer.sv ----
// Exception priority, state save and vector fetch sequencer
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Simultaneous exceptions are taken reset first, then interrupts, then traps.
// - A trap is always taken in the execution state, with no mask able to stop it.
// - Reset handling starts on the low-to-high edge of the chip init pin.
// - Interrupts wait until the current instruction or exception sequence is done.
// - Interrupts and traps push the program counter and flag word first.
// - After the save the interrupt mask bit in the flag word is set to one.
// - The table entry of the accepted source is read and execution resumes there.
// - Reset skips the save, sets the mask and fetches vector zero.
// - Each vector's entry sits at four times its number.
// - The four traps use vectors 8 to 11 chosen by the operand.
// - External lines zero to five use vectors 12 to 17 in order.
// - Vectors 1 to 6, 18 and 19 are never given to a source; an internal request naming one is still fetched, with BAD_VECTOR set.
// - The thirty internal sources are vectored within 20 to 60; an internal vector outside that range is still fetched, with BAD_VECTOR set.
// - Entry addresses are the low 16 bits with the upper bits zero.
// - After reset all interrupts, even the nonmaskable one, wait for the first instruction.
module exc_sequencer (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CHIP_INIT_PIN_N,
    input wire logic NMI_REQ,
    input wire logic [5:0] EXT_REQUEST_LINE,
    input wire logic INT_REQ,
    input wire logic [5:0] INT_VECTOR,
    input wire exc_pkg::core_req_t CORE_REQ,
    input wire logic [15:0] CORE_PC,
    input wire logic [7:0] CORE_FLAGS,
    input wire logic [15:0] CORE_SP,
    input wire logic BUS_DONE,
    input wire logic [31:0] BUS_RDATA,
    output exc_pkg::bus_req_t BUS_REQ,
    output logic [7:0] FLAG_WORD_REGISTER,
    output logic [15:0] NEW_PC,
    output logic NEW_PC_VALID,
    output logic [15:0] NEW_SP,
    output logic CORE_HOLD,
    output logic BAD_VECTOR
);
    typedef enum logic [5:0] {
        S_HALT = 6'h01,
        S_IDLE = 6'h02,
        S_PUSH_PC = 6'h04,
        S_PUSH_FLAGS = 6'h08,
        S_MASK = 6'h10,
        S_FETCH = 6'h20
    } state_t;

    state_t state, next_state;
    exc_pkg::bus_req_t next_bus;
    logic [7:0] next_flags;
    logic [15:0] next_pc;
    logic next_pc_valid;
    logic [15:0] next_sp;
    logic next_hold;
    logic next_bad;
    logic pin_prev, next_pin_prev;
    logic first_done, next_first_done;
    logic [1:0] kind, next_kind;
    logic [2:0] ext_index, next_ext_index;
    logic [1:0] trap_op, next_trap_op;
    logic [5:0] int_vec, next_int_vec;
    logic [5:0] vector;
    logic [15:0] entry_addr;
    logic legal;
    logic [2:0] ext_pick;
    logic ext_any;

    exc_vector_map u_map (
        .kind(kind),
        .ext_index(ext_index),
        .trap_operand(trap_op),
        .int_vector(int_vec),
        .vector(vector),
        .entry_addr(entry_addr),
        .legal(legal)
    );

    // Lowest numbered external line wins
    always_comb begin
        ext_pick = 3'h0;
        ext_any = 1'b0;
        for (int i = exc_pkg::EXT_LINES - 1; i >= 0; i--) begin
            if (EXT_REQUEST_LINE[i]) begin
                ext_pick = 3'(i);
                ext_any = 1'b1;
            end
        end
    end

    always_comb begin
        next_state = state;
        next_bus = BUS_REQ;
        next_flags = FLAG_WORD_REGISTER;
        next_pc = NEW_PC;
        next_pc_valid = 1'b0;
        next_sp = NEW_SP;
        next_hold = CORE_HOLD;
        next_bad = BAD_VECTOR;
        next_pin_prev = CHIP_INIT_PIN_N;
        next_first_done = first_done;
        next_kind = kind;
        next_ext_index = ext_index;
        next_trap_op = trap_op;
        next_int_vec = int_vec;
        if (!CHIP_INIT_PIN_N) begin
            next_state = S_HALT;
            next_bus = '0;
            next_hold = 1'b1;
            next_first_done = 1'b0;
        end else if (!pin_prev) begin
            // Rising edge of the init pin starts reset handling at once
            next_kind = 2'h0;
            next_flags = CORE_FLAGS | exc_pkg::FLAG_RESET;
            next_state = S_FETCH;
            next_hold = 1'b1;
            next_first_done = 1'b0;
            next_bad = 1'b0;
            next_bus = '{valid: 1'b1, write: 1'b0, addr: exc_pkg::PC_RESET, wdata: '0};
        end else begin
            unique case (state)
                S_HALT: next_state = S_HALT;
                S_IDLE: begin
                    next_flags = CORE_FLAGS;
                    if (CORE_REQ.boundary) begin
                        next_first_done = 1'b1;
                    end
                    // Interrupts only at a boundary and never before the first instruction
                    if (CORE_REQ.boundary && first_done
                        && (NMI_REQ || (!CORE_FLAGS[exc_pkg::MASK_BIT] && (ext_any || INT_REQ)))) begin
                        next_kind = NMI_REQ ? 2'h2 : (ext_any ? 2'h2 : 2'h3);
                        next_ext_index = NMI_REQ ? 3'h7 : ext_pick;
                        next_int_vec = INT_VECTOR;
                        next_state = S_PUSH_PC;
                    end else if (CORE_REQ.trap_valid) begin
                        next_kind = 2'h1;
                        next_trap_op = CORE_REQ.trap_operand;
                        next_state = S_PUSH_PC;
                    end
                    if (next_state == S_PUSH_PC) begin
                        next_hold = 1'b1;
                        next_sp = CORE_SP - 16'h0004;
                        next_bus = '{valid: 1'b1, write: 1'b1, addr: CORE_SP - 16'h0004,
                                     wdata: {CORE_FLAGS, 8'h00, CORE_PC}};
                    end
                end
                S_PUSH_PC: if (BUS_DONE) begin
                    next_bus.valid = 1'b0;
                    next_state = S_PUSH_FLAGS;
                end
                S_PUSH_FLAGS: next_state = S_MASK;
                S_MASK: begin
                    next_flags[exc_pkg::MASK_BIT] = 1'b1;
                    next_state = S_FETCH;
                    next_bus = '{valid: 1'b1, write: 1'b0, addr: entry_addr, wdata: '0};
                    next_bad = !legal;
                end
                S_FETCH: if (BUS_DONE) begin
                    next_bus.valid = 1'b0;
                    next_pc = BUS_RDATA[15:0];
                    next_pc_valid = 1'b1;
                    next_hold = 1'b0;
                    next_state = S_IDLE;
                end
                default: next_state = S_HALT;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state <= S_HALT;
            BUS_REQ <= '0;
            FLAG_WORD_REGISTER <= exc_pkg::FLAG_RESET;
            NEW_PC <= exc_pkg::PC_RESET;
            NEW_PC_VALID <= 1'b0;
            NEW_SP <= 16'h0000;
            CORE_HOLD <= 1'b1;
            BAD_VECTOR <= 1'b0;
            pin_prev <= 1'b0;
            first_done <= 1'b0;
            kind <= 2'h0;
            ext_index <= 3'h0;
            trap_op <= 2'h0;
            int_vec <= 6'h00;
        end else begin
            state <= next_state;
            BUS_REQ <= next_bus;
            FLAG_WORD_REGISTER <= next_flags;
            NEW_PC <= next_pc;
            NEW_PC_VALID <= next_pc_valid;
            NEW_SP <= next_sp;
            CORE_HOLD <= next_hold;
            BAD_VECTOR <= next_bad;
            pin_prev <= next_pin_prev;
            first_done <= next_first_done;
            kind <= next_kind;
            ext_index <= next_ext_index;
            trap_op <= next_trap_op;
            int_vec <= next_int_vec;
        end
    end
endmodule // exc_sequencer
`default_nettype wire

// ---- dv/exc_props.sv ----
// Assertion checker for the exception sequencer
`timescale 1ns/1ps
`default_nettype none
module exc_props (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CHIP_INIT_PIN_N,
    input wire logic NMI_REQ,
    input wire exc_pkg::core_req_t CORE_REQ,
    input wire logic [15:0] CORE_PC,
    input wire logic [7:0] CORE_FLAGS,
    input wire logic [15:0] CORE_SP,
    input wire logic BUS_DONE,
    input wire logic [31:0] BUS_RDATA,
    input wire exc_pkg::bus_req_t BUS_REQ,
    input wire logic [7:0] FLAG_WORD_REGISTER,
    input wire logic [15:0] NEW_PC,
    input wire logic NEW_PC_VALID,
    input wire logic CORE_HOLD
);
default clocking @(posedge MCLK); endclocking
default disable iff (RESET);
wire logic idle = !CORE_HOLD && !NEW_PC_VALID && CHIP_INIT_PIN_N;
wire logic [15:0] rd_lo = BUS_RDATA[15:0];
pin_rise_a: assert property ($rose(CHIP_INIT_PIN_N)
    |-> ##[1:2] (BUS_REQ.valid && !BUS_REQ.write && BUS_REQ.addr == 16'h0000 && FLAG_WORD_REGISTER[7]))
    else $error("reset fetch not at entry zero");
trap_push_a: assert property (idle && CORE_REQ.trap_valid |=> BUS_REQ.valid && BUS_REQ.write
    && BUS_REQ.addr == $past(CORE_SP) - 16'h0004 && BUS_REQ.wdata == {$past(CORE_FLAGS), 8'h00, $past(CORE_PC)})
    else $error("trap did not push state");
push_order_a: assert property (BUS_DONE && BUS_REQ.valid && BUS_REQ.write
    |=> !BUS_REQ.valid ##2 (BUS_REQ.valid && !BUS_REQ.write && FLAG_WORD_REGISTER[7]))
    else $error("mask and fetch out of order after push");
vec_addr_a: assert property (BUS_REQ.valid && !BUS_REQ.write
    |-> BUS_REQ.addr[1:0] == 2'b00 && BUS_REQ.addr[15:8] == 8'h00) else $error("bad table entry address");
new_pc_a: assert property (BUS_DONE && BUS_REQ.valid && !BUS_REQ.write
    |=> NEW_PC_VALID && NEW_PC == $past(rd_lo) && !CORE_HOLD) else $error("handler address not taken");
pc_pulse_a: assert property (NEW_PC_VALID |=> !NEW_PC_VALID) else $error("handler valid too long");
seq_hold_a: assert property (disable iff (RESET || !CHIP_INIT_PIN_N)
    BUS_REQ.valid && !BUS_DONE |=> BUS_REQ.valid && $stable(BUS_REQ.addr) && $stable(BUS_REQ.write))
    else $error("sequence disturbed mid access");
masked_int_a: assert property (idle && CORE_FLAGS[7] && !NMI_REQ && !CORE_REQ.trap_valid
    |=> !BUS_REQ.valid) else $error("masked request accepted");
endmodule // exc_props
bind exc_sequencer exc_props u_props (.MCLK, .RESET, .CHIP_INIT_PIN_N, .NMI_REQ, .CORE_REQ, .CORE_PC,
    .CORE_FLAGS, .CORE_SP, .BUS_DONE, .BUS_RDATA, .BUS_REQ, .FLAG_WORD_REGISTER, .NEW_PC, .NEW_PC_VALID,
    .CORE_HOLD);
`default_nettype wire

// ---- dv/bus_model.sv ----
// Memory and stack responder on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module bus_model (
    input wire logic MCLK,
    input wire logic RESET,
    input wire exc_pkg::bus_req_t BUS_REQ,
    output logic BUS_DONE,
    output logic [31:0] BUS_RDATA
);
logic [1:0] waited;
logic [1:0] delay;
// Data toggles outside a read; delay varies 0 to 3
always @(posedge MCLK) begin
    BUS_RDATA <= ~BUS_RDATA;
    BUS_DONE <= 1'b0;
    if (RESET) begin
        BUS_RDATA <= 32'h0F0F0F0F;
        waited <= 2'h0;
        delay <= 2'h0;
    end else if (BUS_REQ.valid && !BUS_DONE) begin
        waited <= waited + 2'h1;
        if (waited == delay) begin
            BUS_DONE <= 1'b1;
            BUS_RDATA <= {~BUS_REQ.addr, BUS_REQ.addr ^ 16'h5A00};
            waited <= 2'h0;
            delay <= delay + 2'h1;
        end
    end
end
endmodule // bus_model
`default_nettype wire

// ---- dv/exc_sequencer_tb.sv ----
// Self-checking bench for the exception sequencer
`timescale 1ns/1ps
`default_nettype none
module exc_sequencer_tb;
logic MCLK = 1'b0;
logic RESET = 1'b1;
logic CHIP_INIT_PIN_N = 1'b0;
logic NMI_REQ = 1'b0;
logic [5:0] EXT_REQUEST_LINE = 6'h00;
logic INT_REQ = 1'b0;
logic [5:0] INT_VECTOR = 6'h00;
exc_pkg::core_req_t CORE_REQ = '0;
logic [15:0] CORE_PC = 16'h0000;
logic [7:0] CORE_FLAGS = 8'h00;
logic [15:0] CORE_SP = 16'h0000;
logic BUS_DONE;
logic [31:0] BUS_RDATA;
exc_pkg::bus_req_t BUS_REQ;
logic [7:0] FLAG_WORD_REGISTER;
logic [15:0] NEW_PC;
logic [15:0] NEW_SP;
logic NEW_PC_VALID;
logic CORE_HOLD;
logic BAD_VECTOR;
int n_fail = 0;
int n_tests = 0;
logic [31:0] seed = 32'h14F9;
exc_pkg::bus_req_t exp_bus[$];
logic [17:0] exp_pc[$];
always #4 MCLK = ~MCLK;
exc_sequencer DUT (.MCLK, .RESET, .CHIP_INIT_PIN_N, .NMI_REQ, .EXT_REQUEST_LINE, .INT_REQ, .INT_VECTOR,
    .CORE_REQ, .CORE_PC, .CORE_FLAGS, .CORE_SP, .BUS_DONE, .BUS_RDATA, .BUS_REQ, .FLAG_WORD_REGISTER,
    .NEW_PC, .NEW_PC_VALID, .NEW_SP, .CORE_HOLD, .BAD_VECTOR);
bus_model PEER (.MCLK, .RESET, .BUS_REQ, .BUS_DONE, .BUS_RDATA);
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
        $display("RESULT: PASS");
    end else begin
        $display("RESULT: FAIL");
    end
    $finish;
endtask
task automatic miss(input string msg);
    n_fail++;
    $display("mismatch %0t %s", $time, msg);
endtask
task automatic cmp_bus(input exc_pkg::bus_req_t got, input logic [15:0] sp);
    exc_pkg::bus_req_t e;
    e = (exp_bus.size() > 0) ? exp_bus.pop_front() : '0;
    n_tests++;
    if (got.valid !== e.valid || got.write !== e.write || got.addr !== e.addr || (e.write && got.wdata !== e.wdata))
        miss("bus access");
    if (e.write && sp !== e.addr) miss("stack pointer after push");
endtask
task automatic cmp_pc(input logic [17:0] got);
    logic [17:0] e;
    e = (exp_pc.size() > 0) ? exp_pc.pop_front() : 18'h00000;
    n_tests++;
    if (got !== e) miss("handler fetch");
endtask
always @(negedge MCLK) begin
    if (BUS_REQ.valid === 1'b1 && BUS_DONE === 1'b1) cmp_bus(BUS_REQ, NEW_SP);
    if (NEW_PC_VALID === 1'b1) cmp_pc({FLAG_WORD_REGISTER[7], BAD_VECTOR, NEW_PC});
end
task automatic wait_pc();
    int k;
    for (k = 0; k < 100 && NEW_PC_VALID !== 1'b1; k++) @(negedge MCLK);
    if (k == 100) miss("no handler fetch");
endtask
// Kind 0 trap, 1 external line, 2 NMI racing a trap, 3 internal
task automatic run(input int kind, input logic [5:0] idx);
    logic [5:0] vec;
    logic [31:0] r;
    r = rnd();
    @(negedge MCLK);
    CORE_PC = r[15:0];
    CORE_SP = {r[31:17], 1'b0};
    CORE_FLAGS = (kind == 1 || kind == 3) ? {1'b0, r[22:16]} : r[23:16];
    vec = kind == 0 ? 6'h08 + idx : kind == 1 ? 6'h0C + idx : kind == 2 ? 6'h07 : idx;
    exp_bus.push_back({1'b1, 1'b1, CORE_SP - 16'h0004, CORE_FLAGS, 8'h00, CORE_PC});
    exp_bus.push_back({1'b1, 1'b0, 8'h00, vec, 2'b00, 32'h00000000});
    exp_pc.push_back({1'b1, kind == 3 && (idx < 6'h14 || idx > 6'h3C), {8'h00, vec, 2'b00} ^ 16'h5A00});
    CORE_REQ.trap_valid = kind == 0 || kind == 2;
    CORE_REQ.trap_operand = idx[1:0];
    CORE_REQ.boundary = kind != 0;
    NMI_REQ = kind == 2;
    EXT_REQUEST_LINE = kind == 1 ? (6'h01 << idx) | 6'h20 : 6'h00;
    INT_REQ = kind == 3;
    INT_VECTOR = idx;
    @(negedge MCLK);
    CORE_REQ = '0;
    wait_pc();
    NMI_REQ = 1'b0;
    EXT_REQUEST_LINE = 6'h00;
    INT_REQ = 1'b0;
    $display("test kind %0d vector %0d done", kind, vec);
endtask
initial begin
    logic [5:0] iv [4];
    iv = '{6'h12, 6'h14, 6'h3C, 6'h14 + 6'(rnd() % 41)};
    repeat (3) @(posedge MCLK);
    @(negedge MCLK);
    RESET = 1'b0;
    repeat (2) @(negedge MCLK);
    exp_bus.push_back({1'b1, 1'b0, 16'h0000, 32'h00000000});
    exp_pc.push_back({1'b1, 1'b0, 16'h5A00});
    CHIP_INIT_PIN_N = 1'b1;
    wait_pc();
    $display("test reset done");
    for (int i = 0; i < 4; i++) run(0, 6'(i));
    // First boundary after reset: unmasked request must still wait
    CORE_FLAGS = 8'h00;
    EXT_REQUEST_LINE = 6'h01;
    CORE_REQ.boundary = 1'b1;
    @(negedge MCLK);
    // Second boundary: mask set, request must be refused
    CORE_FLAGS = 8'h80;
    @(negedge MCLK);
    CORE_REQ = '0;
    repeat (6) @(negedge MCLK);
    EXT_REQUEST_LINE = 6'h00;
    $display("test masked request done");
    for (int i = 0; i < 6; i++) run(1, 6'(i));
    run(2, 6'h01);
    foreach (iv[i]) run(3, iv[i]);
    repeat (4) @(negedge MCLK);
    if (exp_bus.size() != 0 || exp_pc.size() != 0) miss("results missing");
    final_report();
end
initial begin
    #100000;
    miss("watchdog");
    final_report();
end
endmodule // exc_sequencer_tb
`default_nettype wire
